// ---- design/status_core_params.svh ----
// Constants for the common status and service request block.
// Assumes inclusion by status_core only.
`ifndef STATUS_CORE_PARAMS_SVH
`define STATUS_CORE_PARAMS_SVH
`define SB_ERRQ_BIT   2
`define SB_QUES_BIT   3
`define SB_MAV_BIT    4
`define SB_ESB_BIT    5
`define SB_RQS_BIT    6
`define SB_OPER_BIT   7
`define EV_PON_BIT    7
`define EV_OPC_BIT    0
`define EV_ENA_RST    8'h00
`define EV_LATCH_RST  8'h80
`define SR_ENA_RST    8'h00
`define SR_ENA_USED   8'hBF
`endif

// ---- design/status_core_pkg.sv ----
// Types for the common status and service request block.
// Assumes the params header sits beside this file.
package status_core_pkg;
   typedef struct packed {
      logic       ev_ena_wr;
      logic       sr_ena_wr;
      logic       clear_status;
      logic       cls_after_term;
      logic       ev_latch_rd;
      logic       ev_ena_rd;
      logic       sr_ena_rd;
      logic       serial_poll;
      logic [7:0] wdata;
   } status_cmd_t;

   typedef struct packed {
      logic       query_error;
      logic       exec_error;
      logic       cmd_error;
      logic       dev_error;
      logic       user_request;
      logic       request_control;
      logic       op_complete;
      logic       err_queue_ne;
      logic       out_queue_ne;
      logic       ques_summary;
      logic       oper_summary;
   } status_evt_t;

   typedef struct packed {
      logic       rd_valid;
      logic [7:0] rd_data;
      logic       srq;
      logic       clr_err_queue;
      logic       clr_out_queue;
      logic       cancel_opc;
   } status_rsp_t;
endpackage

// ---- design/status_core.sv ----
// Standard event latch, enable masks, status byte and service request.
// Assumes a command parser that issues one-cycle decoded strobes.
`timescale 1ns/1ps
`include "status_core_params.svh"

module status_core (
   input  wire logic                        ref_clk,
   input  wire logic                        sys_rst,
   input  wire status_core_pkg::status_cmd_t cmd,
   input  wire status_core_pkg::status_evt_t evt,
   output      status_core_pkg::status_rsp_t rsp
);
   import status_core_pkg::*;

   typedef struct packed {
      logic [7:0]  ev_ena;
      logic [7:0]  ev_latch;
      logic [7:0]  sr_ena;
      logic [7:0]  sb_prev;
      logic        rqs;
      status_rsp_t rsp;
   } state_t;

   state_t     st_ff;
   state_t     nxt_st;
   logic [7:0] ev_in;
   logic [7:0] sb_now;
   logic [7:0] sb_rise;
   logic       esb;

   // ************************************************
   // Status byte assembly
   // ************************************************
   always_comb begin
      ev_in = {1'b0, evt.user_request, evt.cmd_error, evt.exec_error,
               evt.dev_error, evt.query_error, evt.request_control, evt.op_complete};
      esb = |(st_ff.ev_latch & st_ff.ev_ena);
      sb_now = 8'h00;
      sb_now[`SB_ERRQ_BIT] = evt.err_queue_ne;
      sb_now[`SB_QUES_BIT] = evt.ques_summary;
      sb_now[`SB_MAV_BIT]  = evt.out_queue_ne;
      sb_now[`SB_ESB_BIT]  = esb;
      sb_now[`SB_OPER_BIT] = evt.oper_summary;
      sb_now[`SB_RQS_BIT]  = st_ff.rqs;
      // Rise against last cycle's byte; flag bit never enables
      sb_rise = sb_now & ~st_ff.sb_prev & st_ff.sr_ena & `SR_ENA_USED;
   end

   // ************************************************
   // Next state
   // ************************************************
   always_comb begin
      nxt_st = st_ff;
      nxt_st.rsp.rd_valid = 1'b0;
      nxt_st.rsp.rd_data = 8'h00;
      nxt_st.rsp.clr_err_queue = 1'b0;
      nxt_st.rsp.clr_out_queue = 1'b0;
      nxt_st.rsp.cancel_opc = 1'b0;
      nxt_st.sb_prev = sb_now;

      if (cmd.ev_latch_rd) begin
         nxt_st.rsp.rd_valid = 1'b1;
         nxt_st.rsp.rd_data = st_ff.ev_latch;
         nxt_st.ev_latch = 8'h00;
      end else if (cmd.ev_ena_rd) begin
         nxt_st.rsp.rd_valid = 1'b1;
         nxt_st.rsp.rd_data = st_ff.ev_ena;
      end else if (cmd.sr_ena_rd) begin
         nxt_st.rsp.rd_valid = 1'b1;
         nxt_st.rsp.rd_data = st_ff.sr_ena & `SR_ENA_USED;
      end else if (cmd.serial_poll) begin
         nxt_st.rsp.rd_valid = 1'b1;
         nxt_st.rsp.rd_data = sb_now;
         nxt_st.rqs = 1'b0;
      end

      if (cmd.clear_status) begin
         nxt_st.ev_latch = 8'h00;
         nxt_st.rqs = 1'b0;
         nxt_st.rsp.clr_err_queue = 1'b1;
         nxt_st.rsp.cancel_opc = 1'b1;
         nxt_st.rsp.clr_out_queue = cmd.cls_after_term;
      end

      if (cmd.ev_ena_wr) begin
         nxt_st.ev_ena = cmd.wdata;
      end
      if (cmd.sr_ena_wr) begin
         nxt_st.sr_ena = cmd.wdata & `SR_ENA_USED;
      end

      // New events win over any clear in the same cycle
      nxt_st.ev_latch = nxt_st.ev_latch | ev_in;

      // Set wins over a same-cycle poll or clear
      if (|sb_rise) begin
         nxt_st.rqs = 1'b1;
      end
      nxt_st.rsp.srq = nxt_st.rqs;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st_ff.ev_ena   <= `EV_ENA_RST;
         st_ff.ev_latch <= `EV_LATCH_RST;
         st_ff.sr_ena   <= `SR_ENA_RST;
         st_ff.sb_prev  <= 8'h00;
         st_ff.rqs      <= 1'b0;
         st_ff.rsp      <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rsp = st_ff.rsp;

   // ************************************************
   // Checks
   // ************************************************
   property p_unused_zero;
      @(posedge ref_clk) disable iff (sys_rst)
      cmd.sr_ena_rd && !cmd.ev_latch_rd && !cmd.ev_ena_rd |=> !rsp.rd_data[`SB_RQS_BIT];
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused bit read one");

   property p_srq_rise;
      @(posedge ref_clk) disable iff (sys_rst)
      (|sb_rise) |=> rsp.srq;
   endproperty
   a_srq_rise: assert property (p_srq_rise) else $error("no request on rise");

   property p_rqs_with_srq;
      @(posedge ref_clk) disable iff (sys_rst)
      cmd.serial_poll && !cmd.ev_latch_rd && !cmd.ev_ena_rd && !cmd.sr_ena_rd
      |=> rsp.rd_data[`SB_RQS_BIT] == $past(rsp.srq);
   endproperty
   a_rqs_with_srq: assert property (p_rqs_with_srq) else $error("flag and request split");

   property p_rqs_hold;
      @(posedge ref_clk) disable iff (sys_rst)
      st_ff.rqs && !cmd.serial_poll && !cmd.clear_status |=> st_ff.rqs;
   endproperty
   a_rqs_hold: assert property (p_rqs_hold) else $error("flag dropped");

   property p_poll_data;
      @(posedge ref_clk) disable iff (sys_rst)
      cmd.serial_poll && !cmd.ev_latch_rd && !cmd.ev_ena_rd && !cmd.sr_ena_rd
      |=> rsp.rd_valid && rsp.rd_data == $past(sb_now);
   endproperty
   a_poll_data: assert property (p_poll_data) else $error("poll data wrong");

   property p_cls;
      @(posedge ref_clk) disable iff (sys_rst)
      cmd.clear_status |=> rsp.clr_err_queue && rsp.cancel_opc
      && rsp.clr_out_queue == $past(cmd.cls_after_term);
   endproperty
   a_cls: assert property (p_cls) else $error("clear status effects wrong");

   property p_ena_keep;
      @(posedge ref_clk) disable iff (sys_rst)
      !cmd.ev_ena_wr |=> $stable(st_ff.ev_ena);
   endproperty
   a_ena_keep: assert property (p_ena_keep) else $error("event mask changed");

   property p_latch_clear;
      @(posedge ref_clk) disable iff (sys_rst)
      cmd.ev_latch_rd && ev_in == 8'h00 |=> st_ff.ev_latch == 8'h00
      && rsp.rd_data == $past(st_ff.ev_latch);
   endproperty
   a_latch_clear: assert property (p_latch_clear) else $error("event latch not cleared");

   // ************************************************
   // Checks on the read port
   // ************************************************
   property p_rd_idle;
      @(posedge ref_clk) disable iff (sys_rst)
      !rsp.rd_valid |-> rsp.rd_data == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("stray read data");

   property p_rd_pulse;
      @(posedge ref_clk) disable iff (sys_rst)
      cmd.ev_latch_rd || cmd.ev_ena_rd || cmd.sr_ena_rd || cmd.serial_poll |=> rsp.rd_valid;
   endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("read not answered");

   property p_rd_quiet;
      @(posedge ref_clk) disable iff (sys_rst)
      !(cmd.ev_latch_rd || cmd.ev_ena_rd || cmd.sr_ena_rd || cmd.serial_poll)
      |=> !rsp.rd_valid;
   endproperty
   a_rd_quiet: assert property (p_rd_quiet) else $error("stray read valid");

   property p_ena_rd;
      @(posedge ref_clk) disable iff (sys_rst)
      cmd.ev_ena_rd && !cmd.ev_latch_rd |=> rsp.rd_data == $past(st_ff.ev_ena);
   endproperty
   a_ena_rd: assert property (p_ena_rd) else $error("mask read wrong");

   property p_sr_rd;
      @(posedge ref_clk) disable iff (sys_rst)
      cmd.sr_ena_rd && !cmd.ev_latch_rd && !cmd.ev_ena_rd
      |=> rsp.rd_data == $past(st_ff.sr_ena);
   endproperty
   a_sr_rd: assert property (p_sr_rd) else $error("request mask read");

   property p_poll_low;
      @(posedge ref_clk) disable iff (sys_rst)
      cmd.serial_poll && !cmd.ev_latch_rd && !cmd.ev_ena_rd && !cmd.sr_ena_rd
      |=> rsp.rd_data[1:0] == 2'b00;
   endproperty
   a_poll_low: assert property (p_poll_low) else $error("poll low bits set");

   property p_esb_poll;
      @(posedge ref_clk) disable iff (sys_rst)
      cmd.serial_poll && !cmd.ev_latch_rd && !cmd.ev_ena_rd && !cmd.sr_ena_rd
      |=> rsp.rd_data[`SB_ESB_BIT] == |($past(st_ff.ev_latch) & $past(st_ff.ev_ena));
   endproperty
   a_esb_poll: assert property (p_esb_poll) else $error("summary bit wrong");

   // ************************************************
   // Checks on the event latch and masks
   // ************************************************
   property p_ena_load;
      @(posedge ref_clk) disable iff (sys_rst)
      cmd.ev_ena_wr |=> st_ff.ev_ena == $past(cmd.wdata);
   endproperty
   a_ena_load: assert property (p_ena_load) else $error("mask not loaded");

   property p_ena_zero;
      @(posedge ref_clk) disable iff (sys_rst)
      cmd.ev_ena_wr && cmd.wdata == 8'h00 |=> st_ff.ev_ena == 8'h00;
   endproperty
   a_ena_zero: assert property (p_ena_zero) else $error("mask not zeroed");

   property p_cls_ena;
      @(posedge ref_clk) disable iff (sys_rst)
      cmd.clear_status && !cmd.ev_ena_wr |=> $stable(st_ff.ev_ena);
   endproperty
   a_cls_ena: assert property (p_cls_ena) else $error("clear hit mask");

   property p_sr_load;
      @(posedge ref_clk) disable iff (sys_rst)
      cmd.sr_ena_wr |=> st_ff.sr_ena == ($past(cmd.wdata) & `SR_ENA_USED);
   endproperty
   a_sr_load: assert property (p_sr_load) else $error("request mask load");

   property p_sr_bit6;
      @(posedge ref_clk) disable iff (sys_rst)
      !st_ff.sr_ena[`SB_RQS_BIT];
   endproperty
   a_sr_bit6: assert property (p_sr_bit6) else $error("mask bit six set");

   property p_latch_set;
      @(posedge ref_clk) disable iff (sys_rst)
      (|ev_in) |=> (st_ff.ev_latch & $past(ev_in)) == $past(ev_in);
   endproperty
   a_latch_set: assert property (p_latch_set) else $error("event lost");

   property p_latch_keep;
      @(posedge ref_clk) disable iff (sys_rst)
      !cmd.ev_latch_rd && !cmd.clear_status && ev_in == 8'h00
      |=> $stable(st_ff.ev_latch);
   endproperty
   a_latch_keep: assert property (p_latch_keep) else $error("latch changed");

   property p_cls_latch;
      @(posedge ref_clk) disable iff (sys_rst)
      cmd.clear_status && ev_in == 8'h00 |=> st_ff.ev_latch == 8'h00;
   endproperty
   a_cls_latch: assert property (p_cls_latch) else $error("latch not cleared");

   // ************************************************
   // Checks on the request flag
   // ************************************************
   property p_rqs_cause;
      @(posedge ref_clk) disable iff (sys_rst)
      $rose(st_ff.rqs) |-> $past(|sb_rise);
   endproperty
   a_rqs_cause: assert property (p_rqs_cause) else $error("flag without rise");

   property p_rqs_fall;
      @(posedge ref_clk) disable iff (sys_rst)
      $fell(st_ff.rqs) |-> $past(cmd.serial_poll || cmd.clear_status || sys_rst);
   endproperty
   a_rqs_fall: assert property (p_rqs_fall) else $error("flag cleared wrongly");

   property p_poll_clr;
      @(posedge ref_clk) disable iff (sys_rst)
      st_ff.rqs && cmd.serial_poll && !cmd.ev_latch_rd && !cmd.ev_ena_rd && !cmd.sr_ena_rd
      && !(|sb_rise) |=> !st_ff.rqs;
   endproperty
   a_poll_clr: assert property (p_poll_clr) else $error("poll kept flag");

   property p_srq_hold;
      @(posedge ref_clk) disable iff (sys_rst)
      rsp.srq && !cmd.serial_poll && !cmd.clear_status |=> rsp.srq;
   endproperty
   a_srq_hold: assert property (p_srq_hold) else $error("request dropped");

   property p_no_enable;
      @(posedge ref_clk) disable iff (sys_rst)
      st_ff.sr_ena == 8'h00 && !st_ff.rqs |=> !st_ff.rqs;
   endproperty
   a_no_enable: assert property (p_no_enable) else $error("request unmasked");

   // ************************************************
   // Checks on clear status
   // ************************************************
   property p_cls_quiet;
      @(posedge ref_clk) disable iff (sys_rst)
      !cmd.clear_status
      |=> !rsp.clr_err_queue && !rsp.clr_out_queue && !rsp.cancel_opc;
   endproperty
   a_cls_quiet: assert property (p_cls_quiet) else $error("stray clear pulse");

   property p_cancel;
      @(posedge ref_clk) disable iff (sys_rst)
      rsp.cancel_opc |-> $past(cmd.clear_status);
   endproperty
   a_cancel: assert property (p_cancel) else $error("cancel not caused");

   property p_out_clr;
      @(posedge ref_clk) disable iff (sys_rst)
      rsp.clr_out_queue |-> rsp.clr_err_queue;
   endproperty
   a_out_clr: assert property (p_out_clr) else $error("queue clear alone");
endmodule

// ---- test/bus_ctrl_model.sv ----
// Bus controller model: issues decoded common commands one at a time.
// Assumes status_core_pkg is compiled first.
`timescale 1ns/1ps
module bus_ctrl_model
   import status_core_pkg::*;
(
   input  wire logic        ref_clk,
   output      status_cmd_t cmd,
   input  wire status_rsp_t rsp
);
   initial cmd = '0;
   // One strobe cycle, answer taken after the next edge
   task automatic issue(input logic [7:0] ops, input logic [7:0] d, output status_rsp_t r);
      @(posedge ref_clk);
      cmd <= {ops, d};
      @(posedge ref_clk);
      cmd <= '0;
      #1;
      r = rsp;
   endtask
endmodule

// ---- test/common_status_service_request_tb_top.sv ----
// Bench for status_core checking latch, masks and flag against expected values worked out inline.
// Assumes bus_ctrl_model drives cmd; the bench drives the event and status inputs on evt.
`timescale 1ns/1ps
module common_status_service_request_tb_top;
   import status_core_pkg::*;
   logic        ref_clk, sys_rst;
   status_evt_t evt;
   status_cmd_t cmd;
   status_rsp_t rsp, r;
   int          failures, samples_checked, seed, i;
   logic [7:0]  m, e, sb, s;
   status_core DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd(cmd), .evt(evt), .rsp(rsp));
   bus_ctrl_model host (.ref_clk(ref_clk), .cmd(cmd), .rsp(rsp));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("failures %0d samples_checked %0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #60000;
      failures++;
      end_of_test();
   end
   // ****************
   // Main sequence
   // ****************
   initial begin
      failures = 0;
      samples_checked = 0;
      seed = 39019;
      sys_rst = 1'b1;
      evt = '0;
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      host.issue(8'h08, 8'h00, r);
      chk("latch", r.rd_data, 8'h80);
      host.issue(8'h08, 8'h00, r);
      chk("latch", r.rd_data, 8'h00);
      host.issue(8'h04, 8'h00, r);
      chk("mask", r.rd_data, 8'h00);
      for (i = 0; i < 8; i++) begin
         m = 8'($random(seed));
         e = 8'($random(seed)) & 8'h7F;
         host.issue(8'h80, m, r);
         host.issue(8'h40, 8'h20, r);
         host.issue(8'h04, 8'h00, r);
         chk("mask", r.rd_data, m);
         chk("valid", {7'h0, r.rd_valid}, 8'h01);
         @(posedge ref_clk) evt <= {e[2], e[4], e[5], e[3], e[6], e[1], e[0], 4'h0};
         @(posedge ref_clk) evt <= '0;
         repeat (3) @(posedge ref_clk);
         #1;
         sb = (|(e & m)) ? 8'h60 : 8'h00;
         chk("srq", {7'h0, rsp.srq}, {7'h0, sb[6]});
         host.issue(8'h01, 8'h00, r);
         chk("poll", r.rd_data, sb);
         host.issue(8'h01, 8'h00, r);
         chk("poll", r.rd_data, sb & 8'h20);
         if (i[1]) begin
            host.issue(8'h08, 8'h00, r);
            chk("latch", r.rd_data, e);
         end
         host.issue(8'h20 | (i[0] << 4), 8'h00, r);
         chk("clears", {5'h0, r.clr_err_queue, r.clr_out_queue, r.cancel_opc},
             {5'h0, 1'b1, i[0], 1'b1});
         chk("valid", {7'h0, r.rd_valid}, 8'h00);
         chk("idle_data", r.rd_data, 8'h00);
         host.issue(8'h08, 8'h00, r);
         chk("latch", r.rd_data, 8'h00);
         host.issue(8'h04, 8'h00, r);
         chk("mask", r.rd_data, m);
         host.issue(8'h01, 8'h00, r);
         chk("poll", r.rd_data, 8'h00);
      end
      host.issue(8'h40, 8'hFF, r);
      host.issue(8'h02, 8'h00, r);
      chk("sr_mask", r.rd_data, 8'hBF);
      s = (8'($random(seed)) & 8'h9C) | 8'h04;
      @(posedge ref_clk) evt <= {7'h0, s[2], s[4], s[3], s[7]};
      @(posedge ref_clk) evt <= '0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk("srq", {7'h0, rsp.srq}, 8'h01);
      host.issue(8'h01, 8'h00, r);
      chk("poll", r.rd_data, 8'h40);
      @(posedge ref_clk) evt <= {7'h0, s[2], s[4], s[3], s[7]};
      repeat (2) @(posedge ref_clk);
      host.issue(8'h01, 8'h00, r);
      chk("poll", r.rd_data, s | 8'h40);
      host.issue(8'h01, 8'h00, r);
      chk("poll", r.rd_data, s);
      @(posedge ref_clk) evt <= '0;
      host.issue(8'h80, 8'h00, r);
      host.issue(8'h04, 8'h00, r);
      chk("mask", r.rd_data, 8'h00);
      host.issue(8'h80, 8'hA5, r);
      @(posedge ref_clk) sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      host.issue(8'h04, 8'h00, r);
      chk("mask", r.rd_data, 8'h00);
      host.issue(8'h08, 8'h00, r);
      chk("latch", r.rd_data, 8'h80);
      host.issue(8'h01, 8'h00, r);
      chk("poll", r.rd_data, 8'h00);
      end_of_test();
   end
endmodule
